// file: bench/lirar_checker.sv
// Assertions on the ports of the routing register bank.
// Assumes a bind onto lirar_regs from the bench top.
`timescale 1ns/100ps
module lirar_checker (
	input wire logic        clk, reset, psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0]  pstrb, left_atten, right_atten,
	input wire logic        left_diff_mode, left_connect, right_connect, right_adc_power
);
	import lirar_pkg::*;
	// One clock domain, so clocking and reset are shared
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_acc; psel && penable && !pready; endsequence
	sequence s_wr; pready && pwrite && pstrb[0]; endsequence
	property p_wait; s_acc |-> ##[1:2] pready; endproperty
	a_wait: assert property (p_wait) else $error("access not answered");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err; pready |-> pslverr == (paddr != lirar_left_addr && paddr != lirar_right_addr);
	endproperty
	a_err: assert property (p_err) else $error("bad error flag");
	property p_lcon; left_connect == (left_atten <= lirar_atten_max); endproperty
	a_lcon: assert property (p_lcon) else $error("left connect wrong");
	property p_rcon; right_connect == (right_atten <= lirar_atten_max); endproperty
	a_rcon: assert property (p_rcon) else $error("right connect wrong");
	property p_lrd; pready && !pwrite && paddr == lirar_left_addr |-> prdata[2:0] == 3'h0;
	endproperty
	a_lrd: assert property (p_lrd) else $error("left low bits not zero");
	property p_wl; s_wr and paddr == lirar_left_addr |-> left_atten == pwdata[6:3]
		&& left_diff_mode == pwdata[7]; endproperty
	a_wl: assert property (p_wl) else $error("left write lost");
	property p_pow; s_wr and paddr == lirar_right_addr |-> right_adc_power == pwdata[2]
		##1 $stable(right_adc_power); endproperty
	a_pow: assert property (p_pow) else $error("power bit wrong");
	// Fields move only with a write answer
	property p_hold; !pready |-> $stable({left_diff_mode, left_atten, right_atten}); endproperty
	a_hold: assert property (p_hold) else $error("field changed unasked");
endmodule : lirar_checker

// file: bench/lirar_regs_tb.sv
// Self-checking bench for the routing register bank.
// Assumes the bank answers APB with pready after a wait state.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t %h %h", $time, a, b); end end
module lirar_regs_tb;
	import lirar_pkg::*;
	logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, fs_tick = 0, pready;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  pstrb = 4'hf, la, ra;
	logic        ldm, lcon, rdm, rcon, rpow, rtick, err, pslverr;
	lirar_step_t rmode;
	int          err_count = 0, samples_checked = 0, ticks = 0, t0;
	always #5 clk = ~clk;
	always @(posedge clk) ticks <= ticks + (rtick === 1'b1);
	lirar_regs dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fs_tick(fs_tick), .left_diff_mode(ldm), .left_atten(la),
		.left_connect(lcon), .right_diff_mode(rdm), .right_atten(ra), .right_connect(rcon),
		.right_adc_power(rpow), .right_step_tick(rtick), .right_step_mode(rmode));
	// Holds the request until pready is high at a rising edge, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// Looked at mid-cycle: the value the next rising edge samples; watchdog ends a hang
		do @(negedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge clk);
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb
	task automatic t_rst_err();
		apb(0, lirar_right_addr, 0); `CHK(rd, 32'h0000_0078)
		apb(1, 12'h05c, 32'h0000_00ff); `CHK(err, 1'b1)
		pstrb <= 0; apb(1, lirar_left_addr, 0); pstrb <= 4'hf;
		apb(0, lirar_left_addr, 0); `CHK(rd, 32'h0000_0078)
		$display("t_rst_err done");
	endtask : t_rst_err
	// Every legal code and the off code; reserved codes and nonzero low bits never sent
	task automatic t_left();
		logic [3:0] c;
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			if (c > 4'h8 && c < 4'hf) continue;
			apb(1, lirar_left_addr, {24'h00_0000, c[0], c, 3'h0});
			`CHK({ldm, la, lcon}, {c[0], c, c <= 4'h8})
			apb(0, lirar_left_addr, 0); `CHK(rd, {24'h00_0000, c[0], c, 3'h0})
		end
		$display("t_left done");
	endtask : t_left
	task automatic t_right();
		for (int m = 0; m < 4; m++) begin
			// Left side is disconnected here, so its mode need not match
			apb(1, lirar_right_addr, 32'h0000_00c4 | m);
			`CHK({rcon, rpow, rdm}, 3'h7)
			@(posedge clk); `CHK(rmode, m > 1 ? lirar_step_one_t_off : lirar_step_t'(m))
			t0 = ticks;
			repeat (4) begin fs_tick <= 1; @(posedge clk); fs_tick <= 0; repeat (3) @(posedge clk); end
			`CHK(ticks - t0, m == 0 ? 4 : m == 1 ? 2 : 0)
			apb(0, lirar_right_addr, 0); `CHK(rd, 32'h0000_00c4 | m)
		end
		apb(1, lirar_right_addr, 32'h0000_0078); `CHK({rcon, rpow}, 2'h0)
		$display("t_right done");
	endtask : t_right
	task automatic wrap_up();
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (2) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		t_rst_err();
		t_left();
		t_right();
		wrap_up();
	end
	// Whole run needs well under a thousand cycles
	initial begin #20000; err_count++; wrap_up(); end
endmodule : lirar_regs_tb
bind lirar_regs lirar_checker chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pstrb(pstrb), .left_atten(left_atten), .right_atten(right_atten),
	.left_diff_mode(left_diff_mode), .left_connect(left_connect),
	.right_connect(right_connect), .right_adc_power(right_adc_power));

// file: hdl/lirar_pkg.sv
// Constants for the right line input to ADC routing register bank.
// Assumes an APB slave with 32-bit data; each register on one aligned word.
// Overview of operation
// [RULE1] Bit 7 of both registers: 0 single-ended, 1 fully differential; resets 0.
// [RULE2] Software programs the same input mode in both registers when routed to both.
// [RULE3] Bits 6..3 attenuate: 0000 is 0 dB, 1.5 dB per code, 1000 is -12 dB.
// [RULE4] A valid code in the left register connects the input to left mix; 1111 not.
// [RULE5] A valid code in the right register connects the input to right mix; 1111 not.
// [RULE6] Software never writes reserved attenuation codes 1001 to 1110.
// [RULE7] Left register bits 2..0 are read-only zeros; software writes zeros there.
// [RULE8] Right register bit 2 powers the right ADC channel; resets 0, powered down.
// [RULE9] Right register bits 1..0: 00 step each sample, 01 every two, 1x none.
// [RULE10] Writable fields hold the last written value; reads return it.
package lirar_pkg;
	// Printed offsets are not multiples of four, so they are indices
	localparam logic [7:0]  lirar_left_index   = 8'h15;
	localparam logic [7:0]  lirar_right_index  = 8'h16;
	localparam logic [11:0] lirar_left_addr    = {2'b00, lirar_left_index, 2'b00};
	localparam logic [11:0] lirar_right_addr   = {2'b00, lirar_right_index, 2'b00};
	localparam int          lirar_mode_bit     = 7;
	localparam int          lirar_atten_msb    = 6;
	localparam int          lirar_atten_lsb    = 3;
	localparam int          lirar_power_bit    = 2;
	localparam logic [3:0]  lirar_atten_max    = 4'h8;
	localparam logic [3:0]  lirar_atten_off    = 4'hf;
	localparam logic [7:0]  lirar_left_reset   = 8'h78;
	localparam logic [7:0]  lirar_right_reset  = 8'h78;
	localparam logic [7:0]  lirar_left_wmask   = 8'hf8;
	localparam logic [7:0]  lirar_right_wmask  = 8'hff;
	localparam logic [1:0]  lirar_step_every   = 2'h0;
	localparam logic [1:0]  lirar_step_second  = 2'h1;

	typedef enum logic [1:0] {
		lirar_step_one_t_one,
		lirar_step_one_t_two,
		lirar_step_one_t_off
	} lirar_step_t;
endpackage : lirar_pkg

// file: hdl/lirar_regs.sv
// Routing register bank for the right line input, APB slave with control outputs.
// Assumes fs_tick is a one-cycle pulse per sample period, synchronous to clk.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
module lirar_regs (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  fs_tick,
	output logic                       left_diff_mode,
	output logic      [3:0]            left_atten,
	output logic                       left_connect,
	output logic                       right_diff_mode,
	output logic      [3:0]            right_atten,
	output logic                       right_connect,
	output logic                       right_adc_power,
	output logic                       right_step_tick,
	output lirar_pkg::lirar_step_t     right_step_mode
);
	import lirar_pkg::*;

	logic [7:0]  left_reg;
	logic [7:0]  right_reg;
	logic [7:0]  next_left_reg;
	logic [7:0]  next_right_reg;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        half_phase;
	logic        next_half_phase;
	logic        next_step_tick;
	lirar_step_t next_step_mode;

	logic access;
	logic wr_left;
	logic wr_right;
	assign access   = psel && penable && !pready;
	assign wr_left  = access && pwrite && pstrb[0] && (paddr == lirar_left_addr);
	assign wr_right = access && pwrite && pstrb[0] && (paddr == lirar_right_addr);

	// Register storage and APB answer; one wait state so outputs stay registered
	always_comb begin
		next_left_reg  = left_reg;
		next_right_reg = right_reg;
		next_prdata    = 32'h0000_0000;
		next_pready    = access;
		next_pslverr   = 1'b0;
		if (wr_left) begin
			next_left_reg = pwdata[7:0] & lirar_left_wmask; // [RULE7] [RULE10]
		end else if (wr_right) begin
			next_right_reg = pwdata[7:0] & lirar_right_wmask; // [RULE10]
		end
		if (access) begin
			if (paddr == lirar_left_addr) begin
				next_prdata = {24'h00_0000, left_reg}; // [RULE10]
			end else if (paddr == lirar_right_addr) begin
				next_prdata = {24'h00_0000, right_reg};
			end else begin
				next_pslverr = 1'b1; // Unmapped address answers with error
			end
		end
		if (!pwrite) begin
			next_prdata = next_pslverr ? 32'h0000_0000 : next_prdata;
		end else begin
			next_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			left_reg  <= lirar_left_reset;
			right_reg <= lirar_right_reset;
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else begin
			left_reg  <= next_left_reg;
			right_reg <= next_right_reg;
			prdata    <= next_prdata;
			pready    <= next_pready;
			pslverr   <= next_pslverr;
		end
	end

	// Soft-step pacing: sample tick divided per step field
	always_comb begin
		next_half_phase = half_phase;
		next_step_tick  = 1'b0;
		next_step_mode  = lirar_step_one_t_off;
		case (right_reg[1:0]) // [RULE9]
			lirar_step_every: begin
				next_step_mode = lirar_step_one_t_one;
				next_step_tick = fs_tick;
			end
			lirar_step_second: begin
				next_step_mode = lirar_step_one_t_two;
				if (fs_tick) begin
					next_half_phase = !half_phase;
					next_step_tick  = half_phase;
				end
			end
			default: begin
				next_half_phase = 1'b0; // Disabled: no steps, phase parked
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			half_phase      <= 1'b0;
			right_step_tick <= 1'b0;
			right_step_mode <= lirar_step_one_t_one;
		end else begin
			half_phase      <= next_half_phase;
			right_step_tick <= next_step_tick;
			right_step_mode <= next_step_mode;
		end
	end

	// Analog controls decoded from stored fields, registered for clean outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			left_diff_mode  <= 1'b0;
			left_atten      <= lirar_atten_off;
			left_connect    <= 1'b0;
			right_diff_mode <= 1'b0;
			right_atten     <= lirar_atten_off;
			right_connect   <= 1'b0;
			right_adc_power <= 1'b0;
		end else begin
			left_diff_mode  <= next_left_reg[lirar_mode_bit]; // [RULE1]
			left_atten      <= next_left_reg[lirar_atten_msb:lirar_atten_lsb]; // [RULE3]
			// Reserved codes are treated as disconnected, safest for the mix
			left_connect    <= next_left_reg[lirar_atten_msb:lirar_atten_lsb]
				<= lirar_atten_max; // [RULE4]
			right_diff_mode <= next_right_reg[lirar_mode_bit]; // [RULE1]
			right_atten     <= next_right_reg[lirar_atten_msb:lirar_atten_lsb]; // [RULE3]
			right_connect   <= next_right_reg[lirar_atten_msb:lirar_atten_lsb]
				<= lirar_atten_max; // [RULE5]
			right_adc_power <= next_right_reg[lirar_power_bit]; // [RULE8]
		end
	end
endmodule : lirar_regs
